// ===== module_sideband_control_tb.sv
`timescale 1ns/10ps
module module_sideband_control_tb;
  import msc_pkg::*;
  localparam int RMIN = 20;
  localparam int INIT = 50;
  logic        aclk, aresetn, fault_event, high_power, mgmt_ready, irq;
  logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, got;
  logic [1:0]  bresp, rresp, resp;
  int          n_mismatch, n_compared;
  msc_link_if lnk ();
  msc_module_end #(.RST_MIN(RMIN), .INIT_CYCLES(INIT)) msc_module_end_i (.aclk(aclk),
    .aresetn(aresetn), .lnk(lnk.dev), .fault_event(fault_event), .high_power(high_power),
    .mgmt_ready(mgmt_ready));
  msc_host_end #(.QTR(2)) msc_host_end_i (.aclk(aclk), .aresetn(aresetn), .lnk(lnk.host),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq(irq));
  msc_sva #(.RST_MIN(RMIN), .INIT_CYCLES(INIT)) msc_sva_i (.aclk(aclk), .aresetn(aresetn),
    .module_select_n(lnk.module_select_n), .module_reset_n(lnk.module_reset_n),
    .init_sel_oe(lnk.init_sel_oe), .init_control_select(lnk.init_control_select),
    .int_bit(lnk.int_bit), .int_oe(lnk.int_oe), .module_present_n(lnk.module_present_n),
    .sda_dev_oe(lnk.sda_dev_oe));
  // ----
  // bus tasks
  // ----
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic tout;
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : tout
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    do @(posedge aclk); while (!(awr && wrdy) && ++k < 50);
    awv <= 1'b0;
    wv  <= 1'b0;
    br  <= 1'b1;
    do @(posedge aclk); while (!bv && ++k < 100);
    resp = bresp;
    br  <= 1'b0;
    if (k >= 100) tout();
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge aclk); while (!arr && ++k < 50);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv && ++k < 100);
    got = rd;
    resp = rresp;
    rr  <= 1'b0;
    if (k >= 100) tout();
  endtask : rdreg
  // one serial transfer, leaves the final status word in got
  task automatic ser(input logic [31:0] cmd);
    int k;
    k = 0;
    wr(REG_CMD, cmd);
    do begin
      rdreg(REG_STAT);
      k++;
    end while (got[STAT_BUSY] && k < 400);
    if (k >= 400) tout();
  endtask : ser
  // ----
  // sequence
  // ----
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, fault_event, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, n_mismatch, n_compared} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(REG_IMASK, 32'h7);
    cmp({30'h0, resp}, {30'h0, RESP_OKAY});
    wr(REG_CTRL, 32'h1);
    repeat (INIT + 20) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1);
    cmp({31'h0, lnk.interrupt_n}, 32'h0);
    ser(32'h10000);
    cmp(got & 32'h010E, 32'h0008);
    ser(32'h10001);
    cmp(got & 32'hFF06, 32'h0104);
    cmp({30'h0, high_power, mgmt_ready}, 32'h1);
    cmp({31'h0, lnk.interrupt_n}, 32'h1);
    ser(32'h00102);
    cmp({31'h0, high_power}, 32'h1);
    @(posedge aclk);
    fault_event <= 1'b1;
    @(posedge aclk);
    fault_event <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp({31'h0, lnk.interrupt_n}, 32'h0);
    ser(32'h10001);
    cmp(got & 32'hFF02, 32'h0200);
    cmp({31'h0, lnk.interrupt_n}, 32'h1);
    rdreg(REG_ISTAT);
    cmp(got & 32'h7, 32'h5);
    wr(REG_IMASK, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr(REG_ISTAT, 32'h7);
    rdreg(REG_ISTAT);
    cmp(got & 32'h7, 32'h0);
    wr(REG_CTRL, 32'h0);
    ser(32'h10000);
    cmp(got & 32'h2, 32'h2);
    rdreg(8'h20);
    cmp({30'h0, resp}, {30'h0, RESP_SLVERR});
    cmp(got, 32'h0);
    wr(8'h20, 32'h1);
    cmp({30'h0, resp}, {30'h0, RESP_SLVERR});
    // software-init mode first, then hardware-init mode
    // init select only moves while the module is held in reset
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, 32'h3 | (m << 2));
      repeat (RMIN + 20) @(posedge aclk);
      cmp({30'h0, high_power, lnk.interrupt_n}, 32'h1);
      wr(REG_CTRL, 32'h1 | (m << 2));
      repeat (INIT + 20) @(posedge aclk);
      cmp({30'h0, high_power, lnk.interrupt_n}, m << 1);
    end
    tally_and_finish();
  end
endmodule : module_sideband_control_tb

// ===== msc_host_end.sv
`timescale 1ns/10ps
module msc_host_end
  import msc_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // sideband link
  msc_link_if.host         lnk,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq
);

  localparam int QW = $clog2(QTR + 1);

  // ------------------------------------------------------------------
  // registers and bus decode
  // ------------------------------------------------------------------
  logic [2:0]  ctrl_q, istat_q, imask_q;
  logic [16:0] cmd_q;
  logic        busy_q, nack_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0]  rdat_q;
  logic [1:0]  sda_s_q, pres_s_q;
  logic [2:0]  int_s_q;

  wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire rd_fire = s_axi_arvalid & ~rvalid_q;
  wire wlo     = wr_fire & s_axi_wstrb[0];
  wire w_ctrl  = wlo & (s_axi_awaddr == REG_CTRL);
  wire w_cmd   = wlo & (s_axi_awaddr == REG_CMD);
  wire w_istat = wlo & (s_axi_awaddr == REG_ISTAT);
  wire w_imask = wlo & (s_axi_awaddr == REG_IMASK);
  wire w_ok    = (s_axi_awaddr == REG_CTRL) | (s_axi_awaddr == REG_CMD)
               | (s_axi_awaddr == REG_STAT) | (s_axi_awaddr == REG_ISTAT)
               | (s_axi_awaddr == REG_IMASK);
  wire [31:0] stat_w = {16'h0, rdat_q, 4'h0, ~pres_s_q[1], int_s_q[1], nack_q, busy_q};
  wire r_ok = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_CMD)
            | (s_axi_araddr == REG_STAT) | (s_axi_araddr == REG_ISTAT)
            | (s_axi_araddr == REG_IMASK);
  wire [31:0] rd_mux = (s_axi_araddr == REG_CTRL)  ? {29'h0, ctrl_q}  :
                       (s_axi_araddr == REG_CMD)   ? {15'h0, cmd_q}   :
                       (s_axi_araddr == REG_STAT)  ? stat_w           :
                       (s_axi_araddr == REG_ISTAT) ? {29'h0, istat_q} :
                       (s_axi_araddr == REG_IMASK) ? {29'h0, imask_q} : 32'h0;

  // ------------------------------------------------------------------
  // serial master
  // ------------------------------------------------------------------
  msc_hst_t    hst_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0]  ph_q, bidx_q;
  logic [3:0]  bit_q;
  logic        frame_q, scl_oe_q, sda_oe_q, done_q;

  wire       tick     = busy_q & (qcnt_q == QW'(QTR - 1));
  wire       rd_cmd   = cmd_q[CMD_RD_BIT];
  wire       reading  = frame_q & (bidx_q == 2'h1);
  wire [1:0] last_idx = (frame_q | rd_cmd) ? 2'h1 : 2'h2;
  wire [7:0] cur_byte = frame_q ? {DEV_ADDR, 1'b1} :
                        (bidx_q == 2'h0) ? {DEV_ADDR, 1'b0} :
                        (bidx_q == 2'h1) ? cmd_q[7:0] : cmd_q[15:8];
  wire       tx_low   = (bit_q < 4'h8) & ~reading & ~cur_byte[3'h7 - bit_q[2:0]];
  wire       sda_in   = sda_s_q[1];
  wire       start    = w_cmd & ~busy_q;  // commands while busy are dropped
  wire       dev_int  = ~int_s_q[1] & int_s_q[2];
  wire [2:0] ev       = {dev_int, done_q & nack_q, done_q};
  wire [2:0] iclr     = w_istat ? s_axi_wdata[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hst_q    <= H_IDLE;
      qcnt_q   <= '0;
      ph_q     <= 2'h0;
      bidx_q   <= 2'h0;
      bit_q    <= 4'h0;
      frame_q  <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
      nack_q   <= 1'b0;
      done_q   <= 1'b0;
      rdat_q   <= 8'h00;
    end else begin
      done_q <= 1'b0;
      qcnt_q <= (start | tick) ? '0 : qcnt_q + QW'(busy_q);
      if (start) begin
        busy_q  <= 1'b1;
        hst_q   <= H_START;
        ph_q    <= 2'h0;
        frame_q <= 1'b0;
        nack_q  <= 1'b0;
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (hst_q)
          H_START: begin
            sda_oe_q <= (ph_q != 2'h0);
            scl_oe_q <= (ph_q >= 2'h2);
            if (ph_q == 2'h3) begin
              hst_q  <= H_BIT;
              bit_q  <= 4'h0;
              bidx_q <= 2'h0;
            end
          end
          H_BIT: begin
            case (ph_q)
              2'h0: sda_oe_q <= tx_low;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: begin
                if (reading && bit_q < 4'h8) rdat_q <= {rdat_q[6:0], sda_in};
                if (!reading && bit_q == 4'h8 && sda_in) nack_q <= 1'b1;
              end
              default: begin
                scl_oe_q <= 1'b1;
                if (bit_q != 4'h8) begin
                  bit_q <= bit_q + 4'h1;
                end else if (nack_q || bidx_q == last_idx) begin
                  hst_q <= H_STOP;
                end else begin
                  bidx_q <= bidx_q + 2'h1;
                  bit_q  <= 4'h0;
                end
              end
            endcase
          end
          H_STOP: begin
            sda_oe_q <= (ph_q < 2'h2);
            scl_oe_q <= (ph_q == 2'h0);
            if (ph_q == 2'h3) begin
              if (!frame_q && rd_cmd && !nack_q) begin
                frame_q <= 1'b1;
                hst_q   <= H_START;
              end else begin
                hst_q  <= H_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          end
          default: hst_q <= H_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // register file, interrupts, pin sync
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= CTRL_RST_VAL;
      cmd_q    <= 17'h0;
      istat_q  <= 3'h0;
      imask_q  <= 3'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0;
      sda_s_q  <= 2'h3;
      pres_s_q <= 2'h3;
      int_s_q  <= 3'h7;
    end else begin
      sda_s_q  <= {sda_s_q[0], lnk.sda};
      pres_s_q <= {pres_s_q[0], lnk.module_present_n};
      int_s_q  <= {int_s_q[1:0], lnk.interrupt_n};
      if (w_ctrl) ctrl_q <= s_axi_wdata[2:0];
      if (start) cmd_q <= s_axi_wdata[16:0];
      if (w_imask) imask_q <= s_axi_wdata[2:0];
      istat_q <= (istat_q & ~iclr) | ev;  // set wins over clear
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= r_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready        = wr_fire;
  assign s_axi_wready         = wr_fire;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = rd_fire;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign irq                  = |(istat_q & imask_q);
  assign lnk.scl_host_bit     = 1'b0;
  assign lnk.scl_host_oe      = scl_oe_q;
  assign lnk.sda_host_bit     = 1'b0;
  assign lnk.sda_host_oe      = sda_oe_q;
  assign lnk.module_select_n  = ~ctrl_q[CTRL_SEL];
  assign lnk.module_reset_n   = ~ctrl_q[CTRL_RST];
  assign lnk.init_sel_bit     = 1'b0;
  assign lnk.init_sel_oe      = ctrl_q[CTRL_HWINIT];

endmodule : msc_host_end

// ===== msc_link_if.sv
`timescale 1ns/10ps
interface msc_link_if;
  logic scl_host_bit, scl_host_oe, scl;
  logic sda_host_bit, sda_host_oe, sda_dev_bit, sda_dev_oe, sda;
  logic module_select_n, module_reset_n;
  logic init_sel_bit, init_sel_oe, init_control_select;
  logic int_bit, int_oe, interrupt_n;
  logic pres_bit, pres_oe, module_present_n;

  // pull-ups on every open-drain line; init select is pulled up here too, not in the module
  assign scl                 = scl_host_oe ? scl_host_bit : 1'b1;
  assign sda                 = (sda_host_oe ? sda_host_bit : 1'b1)
                             & (sda_dev_oe ? sda_dev_bit : 1'b1);
  assign init_control_select = init_sel_oe ? init_sel_bit : 1'b1;
  assign interrupt_n         = int_oe ? int_bit : 1'b1;
  assign module_present_n    = pres_oe ? pres_bit : 1'b1;

  modport dev (
    input  scl, sda, module_select_n, module_reset_n, init_control_select,
    output sda_dev_bit, sda_dev_oe, int_bit, int_oe, pres_bit, pres_oe
  );
  modport host (
    input  sda, interrupt_n, module_present_n,
    output scl_host_bit, scl_host_oe, sda_host_bit, sda_host_oe,
           module_select_n, module_reset_n, init_sel_bit, init_sel_oe
  );
endinterface : msc_link_if

// ===== msc_module_end.sv
`timescale 1ns/10ps
module msc_module_end
  import msc_pkg::*;
#(
  parameter int RST_MIN     = RST_MIN_CYC,
  parameter int INIT_CYCLES = INIT_CYC
) (
  // clock and power-up reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // sideband link
  msc_link_if.dev     lnk,
  // user side
  input  wire logic   fault_event,
  output logic        high_power,
  output logic        mgmt_ready
);

  localparam int RW = $clog2(RST_MIN + 1);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [1:0] sel_s_q;
  logic [1:0] rst_s_q;
  logic [1:0] ics_s_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      sel_s_q <= 2'h3;
      rst_s_q <= 2'h3;
      ics_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[1:0], lnk.scl};
      sda_s_q <= {sda_s_q[1:0], lnk.sda};
      sel_s_q <= {sel_s_q[0], lnk.module_select_n};
      rst_s_q <= {rst_s_q[0], lnk.module_reset_n};
      ics_s_q <= {ics_s_q[0], lnk.init_control_select};
    end
  end

  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire sda_hi   = sda_s_q[1];
  wire scl_high = scl_s_q[1] & scl_s_q[2];
  wire bus_start = scl_high & sda_s_q[2] & ~sda_s_q[1];
  wire bus_stop  = scl_high & ~sda_s_q[2] & sda_s_q[1];
  wire selected  = ~sel_s_q[1];

  // ------------------------------------------------------------------
  // reset pulse timing and initialisation
  // ------------------------------------------------------------------
  logic [RW-1:0] rlow_q;
  logic [IW-1:0] init_q;
  logic          ready_q;
  logic [1:0]    flags_q;
  logic          ctrl_q;
  logic          hp_q;

  // a glitch shorter than the minimum is ignored; the count restarts on release
  wire rst_low  = ~rst_s_q[1];
  wire rst_hold = rst_low & (rlow_q == RW'(RST_MIN));
  wire init_end = ~ready_q & (init_q == IW'(INIT_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rlow_q <= '0;
    end else if (!rst_low) begin
      rlow_q <= '0;
    end else if (!rst_hold) begin
      rlow_q <= rlow_q + RW'(1);
    end
  end

  // ------------------------------------------------------------------
  // serial slave
  // ------------------------------------------------------------------
  msc_sst_t   st_q;
  logic [7:0] shreg_q;
  logic [7:0] ptr_q;
  logic [2:0] bcnt_q;
  logic       rw_q;
  logic       sda_oe_q;

  wire [7:0] new_byte = {shreg_q[6:0], sda_hi};
  wire       byte_end = scl_rise & (bcnt_q == 3'h7);
  wire       addr_hit = new_byte[7:1] == DEV_ADDR;
  wire       ack_end  = scl_fall & sda_oe_q;
  wire       wr_stb   = byte_end & (st_q == S_WR);
  wire       rd_load  = (st_q == S_AACK & ack_end & rw_q)
                      | (st_q == S_RACK & scl_rise & ~sda_hi);
  wire [7:0] map_rd   = (ptr_q == MAP_STATUS) ? {7'h0, ~ready_q} :
                        (ptr_q == MAP_FLAGS)  ? {6'h0, flags_q}  :
                        (ptr_q == MAP_CTRL)   ? {7'h0, ctrl_q}   : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= S_IDLE;
      shreg_q  <= 8'h00;
      ptr_q    <= 8'h00;
      bcnt_q   <= 3'h0;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (!selected) begin
      st_q     <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      st_q     <= S_ADDR;
      bcnt_q   <= 3'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      st_q     <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          if (scl_rise) begin
            shreg_q <= new_byte;
            bcnt_q  <= bcnt_q + 3'h1;
          end
          if (byte_end) begin
            case (st_q)
              S_ADDR: begin
                rw_q <= new_byte[0];
                st_q <= addr_hit ? S_AACK : S_IDLE;
              end
              S_PTR: begin
                ptr_q <= new_byte;
                st_q  <= S_PACK;
              end
              default: begin
                ptr_q <= ptr_q + 8'h01;
                st_q  <= S_WACK;
              end
            endcase
          end
        end
        S_AACK, S_PACK, S_WACK: begin
          if (scl_fall && !sda_oe_q) begin
            sda_oe_q <= 1'b1;
          end else if (ack_end) begin
            bcnt_q <= 3'h0;
            if (rd_load) begin
              // first read bit goes out on the same falling edge
              sda_oe_q <= ~map_rd[7];
              shreg_q  <= {map_rd[6:0], 1'b0};
              ptr_q    <= ptr_q + 8'h01;
              st_q     <= S_RD;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= (st_q == S_AACK) ? S_PTR : S_WR;
            end
          end
        end
        S_RD: begin
          if (scl_fall) begin
            sda_oe_q <= ~shreg_q[7];
            shreg_q  <= {shreg_q[6:0], 1'b0};
          end
          if (scl_rise) begin
            bcnt_q <= bcnt_q + 3'h1;
            if (bcnt_q == 3'h7) begin
              st_q <= S_RACK;
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
          end
          if (rd_load) begin
            shreg_q <= map_rd;
            ptr_q   <= ptr_q + 8'h01;
            bcnt_q  <= 3'h0;
            st_q    <= S_RD;
          end else if (scl_rise) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // settings, flags and power mode
  // ------------------------------------------------------------------
  // reading the flag byte clears it, but a flag raised in that cycle survives
  wire       flag_clr = rd_load & (ptr_q == MAP_FLAGS);
  wire [1:0] flag_set = {fault_event, init_end};
  wire [1:0] flags_d  = (flags_q & {2{~flag_clr}}) | flag_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_q  <= '0;
      ready_q <= 1'b0;
      flags_q <= 2'h0;
      ctrl_q  <= 1'b0;
      hp_q    <= 1'b0;
    end else if (rst_hold) begin
      init_q  <= '0;
      ready_q <= 1'b0;
      flags_q <= 2'h0;
      ctrl_q  <= 1'b0;
      hp_q    <= 1'b0;
    end else begin
      if (!ready_q) begin
        init_q <= init_q + IW'(1);
      end
      if (init_end) begin
        ready_q <= 1'b1;
      end
      flags_q <= flags_d;
      if (wr_stb && ptr_q == MAP_CTRL) begin
        ctrl_q <= new_byte[CT_HPEN_BIT];
      end
      // software gate only while init select is high
      hp_q <= ready_q & (ics_s_q[1] ? ctrl_q : 1'b1);
    end
  end

  // ------------------------------------------------------------------
  // pins and user outputs
  // ------------------------------------------------------------------
  assign lnk.sda_dev_bit = 1'b0;
  assign lnk.sda_dev_oe  = sda_oe_q;
  assign lnk.int_bit     = 1'b0;
  assign lnk.int_oe      = |flags_q;
  assign lnk.pres_bit    = 1'b0;
  assign lnk.pres_oe     = 1'b1;
  assign high_power      = hp_q;
  assign mgmt_ready      = ready_q;

endmodule : msc_module_end

// ===== msc_pkg.sv
package msc_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS      = 100;
  localparam int RST_MIN_NS  = 10000;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_NS     = 2000000;
  localparam int INIT_CYC    = INIT_NS / CLK_NS;
  localparam int SCL_NS      = 10000;
  localparam int QTR_CYC     = SCL_NS / (4 * CLK_NS);

  // ------------------------------------------------------------------
  // serial address and module memory map
  // ------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR     = 7'h50;
  localparam logic [7:0] MAP_STATUS   = 8'h00;
  localparam logic [7:0] MAP_FLAGS    = 8'h01;
  localparam logic [7:0] MAP_CTRL     = 8'h02;
  localparam int         ST_PEND_BIT  = 0;
  localparam int         FL_RDONE_BIT = 0;
  localparam int         FL_FAULT_BIT = 1;
  localparam int         CT_HPEN_BIT  = 0;

  // ------------------------------------------------------------------
  // controller registers (axi4-lite byte offsets)
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_CMD      = 8'h04;
  localparam logic [7:0]  REG_STAT     = 8'h08;
  localparam logic [7:0]  REG_ISTAT    = 8'h0C;
  localparam logic [7:0]  REG_IMASK    = 8'h10;
  localparam int          CTRL_SEL     = 0;
  localparam int          CTRL_RST     = 1;
  localparam int          CTRL_HWINIT  = 2;
  localparam int          CMD_RD_BIT   = 16;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_NACK    = 1;
  localparam int          STAT_INTN    = 2;
  localparam int          STAT_PRES    = 3;
  localparam int          IS_DONE      = 0;
  localparam int          IS_NACK      = 1;
  localparam int          IS_DEVINT    = 2;
  localparam logic [2:0]  CTRL_RST_VAL = 3'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // state types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_AACK = 4'h2, S_PTR = 4'h3, S_PACK = 4'h4,
    S_WR   = 4'h5, S_WACK = 4'h6, S_RD   = 4'h7, S_RACK = 4'h8
  } msc_sst_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h2, H_STOP = 2'h3
  } msc_hst_t;

endpackage : msc_pkg

// ===== msc_sva.sv
`timescale 1ns/10ps
module msc_sva
#(
  parameter int RST_MIN     = 100,
  parameter int INIT_CYCLES = 20000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic init_sel_oe,
  input wire logic init_control_select,
  input wire logic int_bit,
  input wire logic int_oe,
  input wire logic module_present_n,
  input wire logic sda_dev_oe
);
  // ----
  // counters: reset low time, cycles since last full reset
  // ----
  int rcnt_q;
  int icnt_q;
  always_ff @(posedge aclk) begin
    rcnt_q <= (!aresetn || module_reset_n) ? 0 : rcnt_q + 1;
    if (!aresetn || rcnt_q > RST_MIN + 4) icnt_q <= 0;
    else if (icnt_q < INIT_CYCLES + 20) icnt_q <= icnt_q + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pres; module_present_n == 1'b0; endproperty
  a_pres: assert property (p_pres) else $error("present line not low");
  property p_int_low; int_oe |-> !int_bit; endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt driven high");
  property p_desel; module_select_n [*5] |-> !sda_dev_oe; endproperty
  a_desel: assert property (p_desel) else $error("data driven while deselected");
  property p_init_pull; !init_sel_oe |-> init_control_select; endproperty
  a_init_pull: assert property (p_init_pull) else $error("init select not high");
  property p_rst_clear; rcnt_q == RST_MIN + 6 |-> !int_oe; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("flags kept in reset");
  property p_done_int; icnt_q == INIT_CYCLES + 10 |-> int_oe; endproperty
  a_done_int: assert property (p_done_int) else $error("no completion interrupt");
  property p_quiet; icnt_q > 0 && icnt_q < INIT_CYCLES - 4 |-> !int_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt before init done");
  property p_int_fall; $rose(int_oe) |-> $past(icnt_q) > INIT_CYCLES - 4; endproperty
  a_int_fall: assert property (p_int_fall) else $error("early interrupt edge");
endmodule : msc_sva
